// ==== common/pmbus_slice_pkg.sv ====
// Constants and types of the PMBus NVM, feature_report and alert-suppress slice.
// Assumes one core clock and an SMBus link whose clock comes from the host.
package pmbus_slice_pkg;
  localparam logic [7:0] CMD_SAVE_ALL  = 8'h15;
  localparam logic [7:0] CMD_LOAD_ALL  = 8'h16;
  localparam logic [7:0] CMD_FEATURE   = 8'h19;
  localparam logic [7:0] CMD_SUPPRESS  = 8'h1b;
  localparam logic [7:0] CODE_VOUT     = 8'h7a;
  localparam logic [7:0] CODE_IOUT     = 8'h7b;
  localparam logic [7:0] PHASE_ALL     = 8'hff;
  localparam logic [7:0] BLOCK_LEN_ONE = 8'h01;
  localparam logic [7:0] READ_FILL     = 8'hff;
  localparam logic [7:0] VOUT_IMPL     = 8'hfc;
  localparam logic [7:0] IOUT_IMPL     = 8'hb0;
  localparam logic [7:0] NVM_DEFAULT   = 8'h00;
  localparam logic       FEAT_PEC      = 1'b1;
  localparam logic [1:0] FEAT_SPEED    = 2'b10;
  localparam logic       FEAT_ALERT    = 1'b1;
  localparam logic       FEAT_FORMAT   = 1'b0;
  localparam logic       FEAT_AVSBUS   = 1'b0;
  localparam logic [1:0] FEAT_RSVD     = 2'b00;
  localparam logic [7:0] FEATURE_BYTE  = {FEAT_PEC, FEAT_SPEED, FEAT_ALERT,
                                          FEAT_FORMAT, FEAT_AVSBUS,
                                          FEAT_RSVD};
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [1:0] CNT_DATALESS  = 2'h1;
  localparam logic [1:0] CNT_WORD      = 2'h3;
  localparam logic [1:0] RD_FIRST      = 2'h0;
  localparam logic [1:0] RD_LAST       = 2'h2;
  localparam int         OP_ITEMS      = 2;
  localparam int         ITEM_VOUT     = 0;
  localparam int         ITEM_IOUT     = 1;
  localparam logic [6:0] ADDR_DEFAULT  = 7'h24;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_SAVE,
    ST_LOAD,
    ST_OVERRIDE
  } nvm_state_t;
endpackage

// ==== common/byte_link_if.sv ====
// Byte-level hand-off between the SMBus bit engine and the interpreter.
// Both ends run on the core clock; pulses last one cycle.
`timescale 1ns/1ps
interface byte_link_if;
  logic       start;
  logic       stop;
  logic       rx_valid;
  logic       first;
  logic [7:0] rx_byte;
  logic       tx_req;
  logic [7:0] tx_byte;
  logic       ack_ok;
  logic       sda_oe;
  logic       sda_lvl;

  modport engine (output start, stop, rx_valid, first, rx_byte, tx_req,
                  output sda_oe, sda_lvl, input tx_byte, ack_ok);
  modport interp (input start, stop, rx_valid, first, rx_byte, tx_req,
                  input sda_oe, sda_lvl, output tx_byte, ack_ok);
endinterface

// ==== src/smbus_bit_engine.sv ====
// SMBus bit engine: synchronises the link pins, finds start and stop,
// shifts bytes in and out and drives the acknowledge bit.
// Assumes the interpreter answers ack_ok and tx_byte before the next SCL fall.
`timescale 1ns/1ps
module smbus_bit_engine
  import pmbus_slice_pkg::*;
(
  // Clock and reset.
  input  wire logic   core_clk_in,
  input  wire logic   rst_in,
  // Link pins.
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  // Byte hand-off.
  byte_link_if.engine lk
);
  typedef struct packed {
    logic       scl_m;
    logic       scl_s;
    logic       scl_d;
    logic       sda_m;
    logic       sda_s;
    logic       sda_d;
    logic       busy;
    logic       first;
    logic       tx;
    logic       ack_phase;
    logic       dead;
    logic       drive_low;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       start;
    logic       stop;
    logic       rx_valid;
    logic       tx_req;
  } eng_t;

  eng_t q;
  eng_t n;
  logic rise;
  logic fall;

  always_comb begin
    n = q;
    n.start = 1'b0;
    n.stop = 1'b0;
    n.rx_valid = 1'b0;
    n.tx_req = 1'b0;
    n.scl_m = scl_in;
    n.scl_s = q.scl_m;
    n.scl_d = q.scl_s;
    n.sda_m = sda_in;
    n.sda_s = q.sda_m;
    n.sda_d = q.sda_s;
    rise = q.scl_s & ~q.scl_d;
    fall = ~q.scl_s & q.scl_d;
    if (q.scl_s && q.scl_d && q.sda_d && !q.sda_s) begin
      n.busy = 1'b1;
      n.first = 1'b1;
      n.tx = 1'b0;
      n.ack_phase = 1'b0;
      n.dead = 1'b0;
      n.drive_low = 1'b0;
      n.bit_cnt = '0;
      n.start = 1'b1;
    end else if (q.scl_s && q.scl_d && !q.sda_d && q.sda_s) begin
      n.busy = 1'b0;
      n.drive_low = 1'b0;
      n.stop = 1'b1;
    end else if (q.busy && !q.dead) begin
      if (rise && !q.ack_phase) begin
        n.bit_cnt = q.bit_cnt + 4'h1;
        if (!q.tx) begin
          n.shift = {q.shift[6:0], q.sda_s};
          n.rx_valid = (q.bit_cnt == BIT_LAST);
        end
      end else if (rise && q.tx && q.sda_s) begin
        // The host did not acknowledge: release the line until a start.
        n.dead = 1'b1;
      end
      if (fall) begin
        if (!q.ack_phase && q.bit_cnt == BITS_PER_BYTE) begin
          n.ack_phase = 1'b1;
          n.drive_low = !q.tx && lk.ack_ok;
          n.dead = !q.tx && !lk.ack_ok;
        end else if (q.ack_phase) begin
          n.ack_phase = 1'b0;
          n.bit_cnt = '0;
          n.first = 1'b0;
          n.tx = q.tx | (q.first & q.shift[0]);
          n.drive_low = 1'b0;
          if (n.tx) begin
            n.drive_low = !lk.tx_byte[7];
            n.shift = {lk.tx_byte[6:0], 1'b0};
            n.tx_req = 1'b1;
          end
        end else if (q.tx) begin
          n.drive_low = !q.shift[7];
          n.shift = {q.shift[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign lk.start = q.start;
  assign lk.stop = q.stop;
  assign lk.rx_valid = q.rx_valid;
  assign lk.first = q.first;
  assign lk.rx_byte = q.shift;
  assign lk.tx_req = q.tx_req;
  assign lk.sda_oe = q.drive_low;
  assign lk.sda_lvl = q.dead;
endmodule

// ==== src/pmbus_nvm_alert_ctrl.sv ====
// PMBus command slice: user-store save and restore, feature_report byte and
// indirect alert-suppress masks, with the alert output they gate.
// Assumes status, phase and strap inputs come from logic on core_clk_in.
//
// Functional notes
// RL1: Restore-all 16h halts regulation and copies user store into operation.
// RL2: After restore, strap-selected items take their last detected pin values.
// RL3: Store entries without an operating location are skipped on restore.
// RL4: Host issues restore only while the phase selector is FFh.
// RL5: Feature_report 19h answers one read-only byte by Read Byte.
// RL6: Feature_report bit 7 set for PEC, bits 6:5 equal 10b.
// RL7: Feature_report bit 4 set: alert pin and alert response supported; code drives alert_n_out but acks only DEV_ADDR.
// RL8: Feature_report bits 3, 2 and 1:0 read as zero.
// RL9: Any feature_report write is invalid data, flagged and alerted.
// RL10: A suppress bit never stops status setting, only alert assertion.
// RL11: Mask write is Write Word 1Bh: low byte code, high byte mask.
// RL12: Mask read is a process call: one-byte code in, one-byte mask out.
// RL13: Mask access only with phase FFh; masks are shared by all phases.
// RL14: Mask bit 0 lets the condition alert, 1 blocks it.
// RL15: Code 7Ah selects the output-voltage mask, bits 7 to 2.
// RL16: Output-voltage mask bits 1:0 always read zero.
// RL17: Code 7Bh selects the output-current mask the same way.
// RL18: Store-all 15h copies operating items into the user store.
// RL19: Masks load from the user store at reset before alerts count.
`timescale 1ns/1ps
module pmbus_nvm_alert_ctrl
  import pmbus_slice_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR    = ADDR_DEFAULT,
  parameter int         STORE_DEPTH = 4
) (
  // Clock and reset.
  input  wire logic                         core_clk_in,
  input  wire logic                         rst_in,
  // SMBus pins; data is open drain.
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out_out,
  output logic                              sda_oe_out,
  // Device state around the slice.
  input  wire logic [7:0]                   phase_sel_in,
  input  wire logic [OP_ITEMS-1:0]          override_sel_in,
  input  wire logic [OP_ITEMS-1:0][7:0]     pin_value_in,
  input  wire logic [7:0]                   output_voltage_status_in,
  input  wire logic [7:0]                   status_iout_in,
  input  wire logic                         clear_faults_in,
  // Results.
  output logic                              regulation_en_out,
  output logic                              alert_n_out,
  output logic                              invalid_data_out
);
  localparam int IDX_W = (STORE_DEPTH > 1) ? $clog2(STORE_DEPTH) : 1;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(STORE_DEPTH - 1);

  if (STORE_DEPTH < OP_ITEMS) begin : g_depth_check
    $error("STORE_DEPTH must hold every operating item");
  end

  typedef struct packed {
    nvm_state_t                   state;
    logic [IDX_W-1:0]             idx;
    logic [STORE_DEPTH-1:0][7:0]  store;
    logic [OP_ITEMS-1:0][7:0]     op;
    logic                         regulate;
    logic                         boot_done;
    logic                         invalid;
    logic                         alert_n;
    logic                         addressed;
    logic                         reading;
    logic                         ack_ok;
    logic [1:0]                   wr_cnt;
    logic [1:0]                   rd_cnt;
    logic [7:0]                   cmd;
    logic [7:0]                   d0;
    logic [7:0]                   d1;
    logic [7:0]                   tx_byte;
  } ctrl_t;

  ctrl_t       q;
  ctrl_t       n;
  byte_link_if lk ();

  smbus_bit_engine smbus_bit_engine_inst (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .lk          (lk)
  );

  function automatic logic [7:0] item_impl(input int i);
    return (i == ITEM_VOUT) ? VOUT_IMPL : IOUT_IMPL;
  endfunction

  // Byte k of a read reply, chosen by the command of the write part.
  function automatic logic [7:0] reply(input ctrl_t s, input logic [1:0] k,
                                       input logic [7:0] phase);
    logic [7:0] r;
    r = READ_FILL;
    // RL5 single feature_report byte
    if (s.cmd == CMD_FEATURE && k == RD_FIRST) begin
      r = FEATURE_BYTE;
    end else if (s.cmd == CMD_SUPPRESS && s.wr_cnt == CNT_WORD &&
                 s.d0 == BLOCK_LEN_ONE && phase == PHASE_ALL) begin
      // RL12 one-byte block reply
      if (k == RD_FIRST) begin
        r = BLOCK_LEN_ONE;
      end else if (k == RD_FIRST + 2'h1 && s.d1 == CODE_VOUT) begin
        r = s.op[ITEM_VOUT];
      end else if (k == RD_FIRST + 2'h1 && s.d1 == CODE_IOUT) begin
        r = s.op[ITEM_IOUT];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic set_inv;
    logic exec;
    set_inv = 1'b0;
    n = q;
    exec = lk.stop && q.addressed && !q.reading && q.state == ST_IDLE;
    unique case (q.state)
      ST_BOOT: begin
        // RL19 masks from backup
        for (int i = 0; i < OP_ITEMS; i++) begin
          n.op[i] = q.store[i] & item_impl(i);
        end
        n.boot_done = 1'b1;
        n.state = ST_IDLE;
      end
      ST_IDLE: begin
      end
      ST_SAVE: begin
        // RL18 copy to store
        for (int i = 0; i < OP_ITEMS; i++) begin
          if (int'(q.idx) == i) begin
            n.store[i] = q.op[i];
          end
        end
        n.idx = q.idx + IDX_W'(1);
        if (q.idx == IDX_LAST) begin
          n.state = ST_IDLE;
        end
      end
      ST_LOAD: begin
        // RL3 unmatched entries skipped
        for (int i = 0; i < OP_ITEMS; i++) begin
          if (int'(q.idx) == i) begin
            n.op[i] = q.store[i] & item_impl(i);
          end
        end
        n.idx = q.idx + IDX_W'(1);
        if (q.idx == IDX_LAST) begin
          n.state = ST_OVERRIDE;
        end
      end
      ST_OVERRIDE: begin
        // RL2 strap values win
        for (int i = 0; i < OP_ITEMS; i++) begin
          if (override_sel_in[i]) begin
            n.op[i] = pin_value_in[i] & item_impl(i);
          end
        end
        n.regulate = 1'b1;
        n.state = ST_IDLE;
      end
    endcase

    if (lk.rx_valid && lk.first) begin
      n.addressed = lk.rx_byte[7:1] == DEV_ADDR && q.state == ST_IDLE;
      n.ack_ok = n.addressed;
      n.reading = lk.rx_byte[0];
      n.rd_cnt = RD_FIRST;
      if (!lk.rx_byte[0]) begin
        n.wr_cnt = '0;
      end
      n.tx_byte = reply(q, RD_FIRST, phase_sel_in);
      // RL13 read refused off phase FFh
      if (n.addressed && lk.rx_byte[0] && q.cmd == CMD_SUPPRESS &&
          phase_sel_in != PHASE_ALL) begin
        set_inv = 1'b1;
      end
    end else if (lk.rx_valid && q.addressed) begin
      unique case (q.wr_cnt)
        2'h0: n.cmd = lk.rx_byte;
        2'h1: n.d0 = lk.rx_byte;
        2'h2: n.d1 = lk.rx_byte;
        default: begin
        end
      endcase
      if (q.wr_cnt != CNT_WORD) begin
        n.wr_cnt = q.wr_cnt + 2'h1;
      end
    end
    if (lk.tx_req) begin
      n.rd_cnt = (q.rd_cnt == RD_LAST) ? RD_LAST : q.rd_cnt + 2'h1;
      n.tx_byte = reply(q, n.rd_cnt, phase_sel_in);
    end

    if (exec) begin
      if (q.wr_cnt == CNT_DATALESS && q.cmd == CMD_SAVE_ALL) begin
        n.state = ST_SAVE;
        n.idx = '0;
      end else if (q.wr_cnt == CNT_DATALESS && q.cmd == CMD_LOAD_ALL) begin
        // RL1 halt regulation, then copy
        n.state = ST_LOAD;
        n.idx = '0;
        n.regulate = 1'b0;
      end else if (q.wr_cnt != '0 && q.cmd == CMD_FEATURE) begin
        // RL9 feature_report is read-only
        // An address-only frame must not replay the previous command byte.
        set_inv = 1'b1;
      end else if (q.cmd == CMD_SUPPRESS && q.wr_cnt == CNT_WORD) begin
        // RL11 low byte code, high byte mask
        if (phase_sel_in != PHASE_ALL) begin
          set_inv = 1'b1;
        end else if (q.d0 == CODE_VOUT) begin
          // RL15 voltage mask, RL16 low bits zero
          n.op[ITEM_VOUT] = q.d1 & VOUT_IMPL;
        end else if (q.d0 == CODE_IOUT) begin
          // RL17 current mask
          n.op[ITEM_IOUT] = q.d1 & IOUT_IMPL;
        end else begin
          set_inv = 1'b1;
        end
      end
    end
    if (lk.stop) begin
      n.addressed = 1'b0;
      n.ack_ok = 1'b0;
    end

    n.invalid = set_inv | (q.invalid & ~clear_faults_in);
    // RL10 RL14 masks gate only the alert
    n.alert_n = !(q.boot_done &&
                  ((|(output_voltage_status_in & ~q.op[ITEM_VOUT])) ||
                   (|(status_iout_in & ~q.op[ITEM_IOUT])) || q.invalid));
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.state <= ST_BOOT;
      q.store <= {STORE_DEPTH{NVM_DEFAULT}};
      q.regulate <= 1'b1;
      q.alert_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign lk.ack_ok = q.ack_ok;
  assign lk.tx_byte = q.tx_byte;
  assign sda_out_out = lk.sda_lvl & 1'b0;
  assign sda_oe_out = lk.sda_oe;
  assign regulation_en_out = q.regulate;
  assign alert_n_out = q.alert_n;
  assign invalid_data_out = q.invalid;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  logic exec_w;
  assign exec_w = lk.stop && q.addressed && !q.reading && q.state == ST_IDLE;
  sequence load_issued;
    exec_w && q.cmd == CMD_LOAD_ALL && q.wr_cnt == CNT_DATALESS;
  endsequence
  sequence feat_read;
    lk.rx_valid && lk.first && lk.rx_byte == {DEV_ADDR, 1'b1} &&
      q.state == ST_IDLE && q.cmd == CMD_FEATURE;
  endsequence
  sequence word_write;
    exec_w && q.cmd == CMD_SUPPRESS && q.wr_cnt == CNT_WORD;
  endsequence

  chk_load_halts_reg: assert property ( // RL1
      load_issued |=> !regulation_en_out [*3])
    else $error("Regulation not halted during restore");
  chk_override_pin: assert property ( // RL2
      q.state == ST_OVERRIDE && override_sel_in[ITEM_VOUT] |=>
      q.op[ITEM_VOUT] == ($past(pin_value_in[ITEM_VOUT]) & VOUT_IMPL))
    else $error("Strap value not applied");
  chk_unmatched_skip: assert property ( // RL3
      q.state == ST_LOAD && int'(q.idx) >= OP_ITEMS |=> $stable(q.op))
    else $error("Unmatched store entry changed operation");
  chk_feat_one_byte: assert property ( // RL5
      lk.tx_req && q.reading && q.cmd == CMD_FEATURE &&
      q.rd_cnt == RD_FIRST |=> lk.tx_byte == READ_FILL)
    else $error("Feature_report reply longer than one byte");
  chk_feat_pec_speed: assert property ( // RL6
      feat_read |=> lk.tx_byte[7:5] == 3'h6)
    else $error("Feature_report PEC or speed wrong");
  chk_feat_alert: assert property (feat_read |=> lk.tx_byte[4])  // RL7
    else $error("Feature_report alert bit clear");
  chk_feat_low_zero: assert property ( // RL8
      feat_read |=> lk.tx_byte[3:0] == 4'h0)
    else $error("Feature_report low bits not zero");
  chk_feat_write_bad: assert property ( // RL9
      exec_w && q.wr_cnt != '0 && q.cmd == CMD_FEATURE
      |=> invalid_data_out ##1 !alert_n_out)
    else $error("Feature_report write not flagged");
  chk_status_alert: assert property ( // RL10
      q.boot_done && (output_voltage_status_in & ~q.op[ITEM_VOUT]) != 8'h00
      |=> !alert_n_out)
    else $error("Unmasked status did not alert");
  chk_mask_write: assert property ( // RL11
      word_write and (phase_sel_in == PHASE_ALL && q.d0 == CODE_VOUT)
      |=> q.op[ITEM_VOUT] == ($past(q.d1) & VOUT_IMPL))
    else $error("Voltage mask write lost");
  chk_phase_only: assert property ( // RL13
      word_write and (phase_sel_in != PHASE_ALL)
      |=> $stable(q.op) && invalid_data_out)
    else $error("Mask written off phase FFh");
  chk_mask_blocks: assert property ( // RL14
      q.boot_done && !q.invalid && status_iout_in == 8'h00 &&
      output_voltage_status_in != 8'h00 &&
      (output_voltage_status_in & ~q.op[ITEM_VOUT]) == 8'h00 |=> alert_n_out)
    else $error("Masked status raised alert");
  chk_vout_low_zero: assert property (q.op[ITEM_VOUT][1:0] == 2'b00)  // RL16
    else $error("Voltage mask low bits set");
  chk_save_copy: assert property ( // RL18
      q.state == ST_SAVE && q.idx == '0 |=> q.store[0] == $past(q.op[0]))
    else $error("Store-all did not copy");
  chk_boot_copy: assert property ( // RL19
      q.state == ST_BOOT
      |=> q.op[ITEM_VOUT] == ($past(q.store[ITEM_VOUT]) & VOUT_IMPL))
    else $error("Masks not loaded at reset");
endmodule

// ==== dv/smbus_host_model.sv ====
// SMBus host model: start, stop, byte transfers and acknowledge bits.
// Assumes a pull-up on the data line; it is paced by the core clock.
`timescale 1ns/1ps
module smbus_host_model (
  // Pacing clock.
  input  wire logic clk_in,
  // Link pins.
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask

  task automatic start();
    sda_pull_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_pull_out = 1'b1;
    half();
    scl_out = 1'b0;
  endtask

  task automatic stop();
    sda_pull_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_pull_out = 1'b0;
    half();
  endtask

  // The clock stands still high between frames.
  task automatic bit_io(input logic b, output logic s);
    sda_pull_out = ~b;
    half();
    scl_out = 1'b1;
    repeat (2) @(negedge clk_in);
    s = sda_in;
    repeat (2) @(negedge clk_in);
    scl_out = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic last,
                      output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(last, s);
    ack = ~s;
  endtask

  task automatic head(input logic [6:0] adr, input logic [23:0] d,
                      input int n, output logic ok);
    logic [7:0] rx;
    logic a;
    start();
    xfer({adr, 1'b0}, 1'b1, rx, ok);
    for (int i = 0; i < n; i++) begin
      xfer(d[23-8*i -: 8], 1'b1, rx, a);
      ok = ok & a;
    end
  endtask

  task automatic frame_write(input logic [6:0] adr, input logic [23:0] d,
                             input int n, output logic ok);
    head(adr, d, n, ok);
    stop();
  endtask

  task automatic frame_read(input logic [6:0] adr, input logic [23:0] d,
                            input int n, output logic [15:0] rd,
                            output logic ok);
    logic a;
    logic [7:0] rx;
    head(adr, d, n, ok);
    start();
    xfer({adr, 1'b1}, 1'b1, rx, a);
    ok = ok & a;
    xfer(8'hff, 1'b0, rd[15:8], a);
    xfer(8'hff, 1'b1, rd[7:0], a);
    stop();
  endtask
endmodule

// ==== dv/pmbus_nvm_alert_ctrl_bench.sv ====
// Bench for the command slice: feature_report, suppress masks, store, restore.
// Assumes the host model in dv and an open-drain data line with pull-up.
`timescale 1ns/1ps
module pmbus_nvm_alert_ctrl_bench;
  import pmbus_slice_pkg::*;
  localparam logic [6:0] ADDR = 7'h24;
  logic            clk, rst, scl, dev_oe, dev_o, pull, clr;
  logic            reg_en, alert_n, inv;
  logic [7:0]      phase, st_v, st_i;
  logic [1:0]      ovr;
  logic [1:0][7:0] pins;
  int              fail_count, num_checks;
  wire             sda = ~(pull | dev_oe);

  pmbus_nvm_alert_ctrl #(.DEV_ADDR(ADDR), .STORE_DEPTH(4))
    pmbus_nvm_alert_ctrl_inst (
    .core_clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda),
    .sda_out_out(dev_o), .sda_oe_out(dev_oe), .phase_sel_in(phase),
    .override_sel_in(ovr), .pin_value_in(pins), .output_voltage_status_in(st_v),
    .status_iout_in(st_i), .clear_faults_in(clr),
    .regulation_en_out(reg_en), .alert_n_out(alert_n),
    .invalid_data_out(inv));

  smbus_host_model smbus_host_model_inst (
    .clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));

  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [23:0] d, input int n);
    logic ok;
    smbus_host_model_inst.frame_write(ADDR, d, n, ok);
    chk1("write ack", 1'b1, ok);
    repeat (8) @(negedge clk);
  endtask

  task automatic rd(input logic [23:0] d, input int n, input logic [15:0] e);
    logic ok;
    logic [15:0] r;
    smbus_host_model_inst.frame_read(ADDR, d, n, r, ok);
    chk1("read ack", 1'b1, ok);
    chk8("read first", e[15:8], r[15:8]);
    chk8("read second", e[7:0], r[7:0]);
  endtask

  task automatic clear();
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_feature();
    logic ok;
    rd(24'h190000, 1, 16'hd0ff);
    smbus_host_model_inst.frame_write(ADDR ^ 7'h01, 24'h190000, 1, ok);
    chk1("foreign address ack", 1'b0, ok);
    wr(24'h195500, 2);
    chk1("invalid flag", 1'b1, inv);
    chk1("alert on invalid", 1'b0, alert_n);
    clear();
    chk1("invalid cleared", 1'b0, inv);
    chk1("alert released", 1'b1, alert_n);
    $display("feature test done");
  endtask

  task automatic t_vout_mask();
    wr(24'h1b7aff, 3);
    rd(24'h1b017a, 3, 16'h01fc);
    for (int b = 2; b < 8; b++) begin
      st_v = 8'h01 << b;
      repeat (3) @(negedge clk);
      chk1("masked alert", 1'b1, alert_n);
    end
    wr(24'h1b7a00, 3);
    for (int b = 2; b < 8; b++) begin
      st_v = 8'h01 << b;
      repeat (3) @(negedge clk);
      chk1("open alert", 1'b0, alert_n);
    end
    st_v = 8'h00;
    repeat (3) @(negedge clk);
    chk1("alert idle", 1'b1, alert_n);
    $display("output voltage mask test done");
  endtask

  task automatic t_iout_phase();
    wr(24'h1b7b90, 3);
    rd(24'h1b017b, 3, 16'h0190);
    st_i = 8'h80;
    repeat (3) @(negedge clk);
    chk1("current alert masked", 1'b1, alert_n);
    st_i = 8'h00;
    phase = 8'h00;
    wr(24'h1b7a04, 3);
    chk1("phase invalid", 1'b1, inv);
    clear();
    phase = 8'hff;
    rd(24'h1b017a, 3, 16'h0100);
    $display("current mask and phase test done");
  endtask

  task automatic restore();
    logic ok;
    int n;
    smbus_host_model_inst.frame_write(ADDR, 24'h160000, 1, ok);
    n = 0;
    while (reg_en !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk1("regulation off", 1'b0, reg_en);
    while (reg_en !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk1("regulation on", 1'b1, reg_en);
    if (n >= 40)
      test_done();
  endtask

  task automatic t_restore();
    wr(24'h1b7a40, 3);
    wr(24'h150000, 1);
    wr(24'h1b7a00, 3);
    restore();
    rd(24'h1b017a, 3, 16'h0140);
    ovr = 2'b01;
    pins[0] = 8'h27;
    restore();
    rd(24'h1b017a, 3, 16'h0124);
    ovr = 2'b00;
    $display("store and restore test done");
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    $display("[FAIL] run time expected finish seen timeout");
    fail_count++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    clr = 1'b0;
    phase = 8'hff;
    ovr = 2'b00;
    pins = '0;
    st_v = 8'h00;
    st_i = 8'h00;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk1("reset regulation", 1'b1, reg_en);
    chk1("reset alert", 1'b1, alert_n);
    chk1("reset invalid", 1'b0, inv);
    chk1("reset data drive", 1'b0, dev_oe);
    chk1("reset data level", 1'b0, dev_o);
    rd(24'h1b017a, 3, 16'h0100);
    $display("reset test done");
    t_feature();
    t_vout_mask();
    t_iout_phase();
    t_restore();
    test_done();
  end
endmodule
